// *** hdl/rss_pkg.sv ***
// Constants, register map and state types for the reset source sequencer
// Summary of operation
// - Four reset sources: pin, soft, two PHY
// - Pin resets every domain, reloads, latches straps
// - Soft reset spares PLL, PHY, straps, exempt bits
// - PMT bit 10 resets PHY, clears after 100us
// - PHY control bit 15 resets PHY, self-clears
// - Host holds pin low 30ms at power-up
// - Ready reads 0 during pin reset, then 1
// - Ready about 22ms; host errors after 100ms
// - Pin pulled high; unused pin needs soft reset
// - Wake write sets ready within 2ms
// - Config bit 0 soft reset, clears after 2us
// - Host soft-resets only after ready seen set
// - EEPROM probe busy bit 31 after pin and soft resets
// - Transmit held until PHY link is up
// - Host refuses access while not ready, except wake write
package rss_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int HW_READY_MS = 22;
  localparam int HW_READY_CYC = HW_READY_MS * 1000 * CLK_MHZ;
  localparam int SOFT_RST_US = 2;
  localparam int SOFT_RST_CYC = SOFT_RST_US * CLK_MHZ;
  localparam int PHY_RST_US = 100;
  localparam int PHY_RST_CYC = PHY_RST_US * CLK_MHZ;
  localparam int WAKE_MS = 2;
  localparam int WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
  localparam int EEP_PROBE_US = 20;
  localparam int EEP_PROBE_CYC = EEP_PROBE_US * CLK_MHZ;
  localparam int PIN_LOW_MS = 30;
  localparam int PIN_LOW_CYC = PIN_LOW_MS * 1000 * CLK_MHZ;
  localparam int POLL_LIMIT_MS = 100;
  localparam int POLL_LIMIT_CYC = POLL_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [7:0] REG_BYTE_TEST = 8'h00;
  localparam logic [7:0] REG_HARDWARE_CONFIG_REG = 8'h04;
  localparam logic [7:0] REG_POWER_MGMT_CTRL_REG = 8'h08;
  localparam logic [7:0] REG_EEP_CMD = 8'h0c;
  localparam logic [7:0] REG_PHY_BCR = 8'h10;
  localparam logic [7:0] REG_PHY_BSR = 8'h14;
  localparam logic [7:0] REG_STRAPS = 8'h18;
  localparam int HWCFG_SOFT_RST_BIT = 0;
  localparam int HWCFG_EXEMPT_LSB = 8;
  localparam int HWCFG_RUN_LSB = 16;
  localparam int CFG_W = 8;
  localparam int PMT_READY_BIT = 0;
  localparam int PMT_PHY_RST_BIT = 10;
  localparam int PMT_PM_MODE_LSB = 12;
  localparam int EEP_BUSY_BIT = 31;
  localparam int BCR_RESET_BIT = 15;
  localparam int BSR_LINK_BIT = 2;
  localparam int STRAP_W = 8;
  localparam logic [1:0] PM_D0 = 2'h0;
  // Arbitrary byte-order pattern
  localparam logic [31:0] BYTE_TEST_VALUE = 32'h5a3c_96e1;
  localparam int DOM_PLL = 0;
  localparam int DOM_HBI = 1;
  localparam int DOM_EXEMPT = 2;
  localparam int DOM_MIL = 3;
  localparam int DOM_MAC = 4;
  localparam int DOM_PHY = 5;
  localparam int DOM_N = 6;
  // ****************************************
  // Host controller register map
  // ****************************************
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_ADDR = 8'h04;
  localparam logic [7:0] HREG_WDATA = 8'h08;
  localparam logic [7:0] HREG_RDATA = 8'h0c;
  localparam logic [7:0] HREG_STATUS = 8'h10;
  localparam int CTRL_PIN_BIT = 0;
  localparam int CTRL_SOFT_BIT = 1;
  localparam int CTRL_ACC_BIT = 2;
  localparam int ADDR_WRITE_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_TIMEOUT_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_READY_BIT = 4;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    ST_PIN_LOW = 3'h0,
    ST_HW_WAIT = 3'h1,
    ST_SOFT = 3'h2,
    ST_READY = 3'h3,
    ST_SLEEP = 3'h4,
    ST_WAKE = 3'h5
  } rss_dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_PIN = 3'h1,
    H_POLL = 3'h2,
    H_HOST_SOFT_RESET_BIT = 3'h3,
    H_ACC = 3'h4
  } rss_host_state_t;
endpackage

// *** hdl/rss_link_if.sv ***
// Link between the device end and the host end: reset pin and register bus
`timescale 1ns/100ps
interface rss_link_if;
  logic hwResetPinOut;
  logic hwResetPinOe;
  logic hwResetPinLevel;
  logic busReq;
  logic busWrite;
  logic [7:0] busAddr;
  logic [31:0] busWdata;
  logic [31:0] busRdata;
  logic busAck;
  // Internal pull-up: pin reads high unless driven
  assign hwResetPinLevel = hwResetPinOe ? hwResetPinOut : 1'b1;
  modport dev (
    input hwResetPinLevel,
    input busReq,
    input busWrite,
    input busAddr,
    input busWdata,
    output busRdata,
    output busAck
  );
  modport host (
    output hwResetPinOut,
    output hwResetPinOe,
    output busReq,
    output busWrite,
    output busAddr,
    output busWdata,
    input busRdata,
    input busAck
  );
endinterface

// *** hdl/rss_delay_timer.sv ***
// Restartable down-counter that pulses done after a loaded number of cycles
`timescale 1ns/100ps
module rss_delay_timer #(
  parameter int WIDTH = rss_pkg::TMR_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [WIDTH-1:0] count,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] remain;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain <= WIDTH'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - WIDTH'(1);
        end
      end
    end
  end
endmodule

// *** hdl/rss_device.sv ***
// Device end: reset sources, domain resets, ready flag and status registers
`timescale 1ns/100ps
module rss_device #(
  parameter int HW_READY_CYCLES = rss_pkg::HW_READY_CYC,
  parameter int PHY_RST_CYCLES = rss_pkg::PHY_RST_CYC,
  parameter int WAKE_CYCLES = rss_pkg::WAKE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  rss_link_if.dev link,
  input wire logic [rss_pkg::STRAP_W-1:0] straps,
  input wire logic phyLinkUp,
  input wire logic txValid,
  output logic [rss_pkg::DOM_N-1:0] domainReset,
  output logic eepromReload,
  output logic deviceReady,
  output logic txGo
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int TW = rss_pkg::TMR_W;
  rss_pkg::rss_dev_state_t state;
  logic pinMeta, pinSync2, pinSync3, pinHigh;
  logic [rss_pkg::STRAP_W-1:0] strapMeta, strapSync, strapLatched;
  logic take, wr, hostOpen;
  logic hwStart, softStart, wakeStart, seqStart;
  logic [TW-1:0] seqCount;
  logic seqDone, phyStart, phyDone, eepDone;
  logic softBit, phyRstBit, phyRegRstBit, eepBusy;
  logic [rss_pkg::CFG_W-1:0] exemptCfg, runCfg;
  logic [1:0] pmMode;
  logic [31:0] readMux;
  logic [rss_pkg::DOM_N-1:0] next_domainReset;

  // ****************************************
  // Reset pin sampling
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta <= 1'b0;
      pinSync2 <= 1'b0;
      pinSync3 <= 1'b0;
    end else begin
      pinMeta <= link.hwResetPinLevel;
      pinSync2 <= pinMeta;
      pinSync3 <= pinSync2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinHigh <= 1'b0;
    end else if (pinSync2 == pinSync3) begin
      pinHigh <= pinSync3;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta <= '0;
      strapSync <= '0;
    end else begin
      strapMeta <= straps;
      strapSync <= strapMeta;
    end
  end

  // ****************************************
  // Bus decode
  // ****************************************
  assign take = link.busReq && !link.busAck;
  assign wr = take && link.busWrite;
  assign hostOpen = (state == rss_pkg::ST_READY);
  assign hwStart = (state == rss_pkg::ST_PIN_LOW) && pinHigh;
  assign softStart = pinHigh && hostOpen && wr && (link.busAddr == rss_pkg::REG_HARDWARE_CONFIG_REG)
    && link.busWdata[rss_pkg::HWCFG_SOFT_RST_BIT];
  assign wakeStart = pinHigh && (state == rss_pkg::ST_SLEEP) && wr
    && (link.busAddr == rss_pkg::REG_BYTE_TEST);
  assign seqStart = hwStart || softStart || wakeStart;
  assign phyStart = pinHigh && hostOpen && wr
    && (((link.busAddr == rss_pkg::REG_POWER_MGMT_CTRL_REG) && link.busWdata[rss_pkg::PMT_PHY_RST_BIT])
    || ((link.busAddr == rss_pkg::REG_PHY_BCR) && link.busWdata[rss_pkg::BCR_RESET_BIT]));

  always_comb begin
    if (hwStart) begin
      seqCount = TW'(HW_READY_CYCLES);
    end else if (softStart) begin
      seqCount = TW'(rss_pkg::SOFT_RST_CYC);
    end else begin
      seqCount = TW'(WAKE_CYCLES);
    end
  end

  // ****************************************
  // Timers
  // ****************************************
  rss_delay_timer #(.WIDTH(TW)) seqTimer (
    .clk(clk),
    .resetn(resetn),
    .start(seqStart),
    .count(seqCount),
    .busy(),
    .done(seqDone)
  );

  rss_delay_timer #(.WIDTH(TW)) phyTimer (
    .clk(clk),
    .resetn(resetn),
    .start(phyStart),
    .count(TW'(PHY_RST_CYCLES)),
    .busy(),
    .done(phyDone)
  );

  rss_delay_timer #(.WIDTH(TW)) eepTimer (
    .clk(clk),
    .resetn(resetn),
    .start(hwStart || softStart),
    .count(TW'(rss_pkg::EEP_PROBE_CYC)),
    .busy(),
    .done(eepDone)
  );

  // ****************************************
  // Sequence state
  // ****************************************
  // ready follows sequence completion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= rss_pkg::ST_PIN_LOW;
    end else if (!pinHigh) begin
      state <= rss_pkg::ST_PIN_LOW;
    end else begin
      case (state)
        rss_pkg::ST_PIN_LOW: state <= rss_pkg::ST_HW_WAIT;
        rss_pkg::ST_HW_WAIT: if (seqDone) state <= rss_pkg::ST_READY;
        rss_pkg::ST_SOFT: if (seqDone) state <= rss_pkg::ST_READY;
        rss_pkg::ST_WAKE: if (seqDone) state <= rss_pkg::ST_READY;
        rss_pkg::ST_SLEEP: if (wakeStart) state <= rss_pkg::ST_WAKE;
        rss_pkg::ST_READY: begin
          if (softStart) begin
            state <= rss_pkg::ST_SOFT;
          end else if (wr && link.busAddr == rss_pkg::REG_POWER_MGMT_CTRL_REG
              && link.busWdata[rss_pkg::PMT_PM_MODE_LSB +: 2] != rss_pkg::PM_D0) begin
            state <= rss_pkg::ST_SLEEP;
          end
        end
        default: state <= rss_pkg::ST_PIN_LOW;
      endcase
    end
  end

  assign deviceReady = hostOpen;
  assign softBit = (state == rss_pkg::ST_SOFT);

  // ****************************************
  // Control fields
  // ****************************************
  // exempt bits survive soft reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exemptCfg <= '0;
    end else if (state == rss_pkg::ST_PIN_LOW) begin
      exemptCfg <= '0;
    end else if (hostOpen && wr && !softStart && link.busAddr == rss_pkg::REG_HARDWARE_CONFIG_REG) begin
      exemptCfg <= link.busWdata[rss_pkg::HWCFG_EXEMPT_LSB +: rss_pkg::CFG_W];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      runCfg <= '0;
    end else if (state == rss_pkg::ST_PIN_LOW || softStart) begin
      runCfg <= '0;
    end else if (hostOpen && wr && link.busAddr == rss_pkg::REG_HARDWARE_CONFIG_REG) begin
      runCfg <= link.busWdata[rss_pkg::HWCFG_RUN_LSB +: rss_pkg::CFG_W];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pmMode <= rss_pkg::PM_D0;
    end else if (state == rss_pkg::ST_PIN_LOW || wakeStart) begin
      pmMode <= rss_pkg::PM_D0;
    end else if (hostOpen && wr && link.busAddr == rss_pkg::REG_POWER_MGMT_CTRL_REG) begin
      pmMode <= link.busWdata[rss_pkg::PMT_PM_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phyRstBit <= 1'b0;
    end else if (phyStart && link.busAddr == rss_pkg::REG_POWER_MGMT_CTRL_REG) begin
      phyRstBit <= 1'b1;
    end else if (phyDone || state == rss_pkg::ST_PIN_LOW) begin
      phyRstBit <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phyRegRstBit <= 1'b0;
    end else if (phyStart && link.busAddr == rss_pkg::REG_PHY_BCR) begin
      phyRegRstBit <= 1'b1;
    end else if (phyDone || state == rss_pkg::ST_PIN_LOW) begin
      phyRegRstBit <= 1'b0;
    end
  end

  // probe busy after pin or soft reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eepBusy <= 1'b1;
    end else if (hwStart || softStart || state == rss_pkg::ST_PIN_LOW) begin
      eepBusy <= 1'b1;
    end else if (eepDone) begin
      eepBusy <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapLatched <= '0;
    end else if (hwStart) begin
      strapLatched <= strapSync;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eepromReload <= 1'b0;
    end else begin
      eepromReload <= hwStart || softStart;
    end
  end

  // ****************************************
  // Domain resets and transmit gate
  // ****************************************
  always_comb begin
    next_domainReset = '0;
    if (state == rss_pkg::ST_PIN_LOW) begin
      next_domainReset = '1;
    end
    if (state == rss_pkg::ST_SOFT) begin
      next_domainReset[rss_pkg::DOM_HBI] = 1'b1;
      next_domainReset[rss_pkg::DOM_MIL] = 1'b1;
      next_domainReset[rss_pkg::DOM_MAC] = 1'b1;
    end
    if (phyRstBit || phyRegRstBit) begin
      next_domainReset[rss_pkg::DOM_PHY] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      domainReset <= '1;
    end else begin
      domainReset <= next_domainReset;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txGo <= 1'b0;
    end else begin
      txGo <= txValid && phyLinkUp && !next_domainReset[rss_pkg::DOM_PHY];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    readMux = '0;
    case (link.busAddr)
      rss_pkg::REG_BYTE_TEST: readMux = rss_pkg::BYTE_TEST_VALUE;
      rss_pkg::REG_HARDWARE_CONFIG_REG: begin
        readMux[rss_pkg::HWCFG_SOFT_RST_BIT] = softBit;
        readMux[rss_pkg::HWCFG_EXEMPT_LSB +: rss_pkg::CFG_W] = exemptCfg;
        readMux[rss_pkg::HWCFG_RUN_LSB +: rss_pkg::CFG_W] = runCfg;
      end
      rss_pkg::REG_POWER_MGMT_CTRL_REG: begin
        readMux[rss_pkg::PMT_READY_BIT] = hostOpen;
        readMux[rss_pkg::PMT_PHY_RST_BIT] = phyRstBit;
        readMux[rss_pkg::PMT_PM_MODE_LSB +: 2] = pmMode;
      end
      rss_pkg::REG_EEP_CMD: readMux[rss_pkg::EEP_BUSY_BIT] = eepBusy;
      rss_pkg::REG_PHY_BCR: readMux[rss_pkg::BCR_RESET_BIT] = phyRegRstBit;
      rss_pkg::REG_PHY_BSR: readMux[rss_pkg::BSR_LINK_BIT] = phyLinkUp && !domainReset[rss_pkg::DOM_PHY];
      rss_pkg::REG_STRAPS: readMux[rss_pkg::STRAP_W-1:0] = strapLatched;
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.busAck <= 1'b0;
      link.busRdata <= '0;
    end else begin
      link.busAck <= take;
      if (take && !link.busWrite) begin
        link.busRdata <= readMux;
      end
    end
  end
endmodule

// *** hdl/rss_host.sv ***
// Host end: APB-driven controller that resets, polls and accesses the device
`timescale 1ns/100ps
module rss_host #(
  parameter int PIN_LOW_CYCLES = rss_pkg::PIN_LOW_CYC,
  parameter int POLL_LIMIT_CYCLES = rss_pkg::POLL_LIMIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  rss_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int TW = rss_pkg::TMR_W;
  rss_pkg::rss_host_state_t state;
  logic [TW-1:0] waitCnt;
  logic [8:0] accAddr;
  logic [31:0] accWdata, accRdata;
  logic done, timeoutErr, refused, devReady, thenSoft;
  logic setup, ctrlWr, accWr, timeUp;

  // ****************************************
  // APB slave
  // ****************************************
  assign pready = penable;
  assign pslverr = 1'b0;
  assign setup = psel && !penable;
  assign ctrlWr = psel && penable && pwrite && paddr == rss_pkg::HREG_CTRL
    && state == rss_pkg::H_IDLE;
  assign accWr = accAddr[rss_pkg::ADDR_WRITE_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (setup) begin
      case (paddr)
        rss_pkg::HREG_ADDR: prdata <= {23'h0, accAddr};
        rss_pkg::HREG_WDATA: prdata <= accWdata;
        rss_pkg::HREG_RDATA: prdata <= accRdata;
        rss_pkg::HREG_STATUS: prdata <= {27'h0, devReady, refused, timeoutErr, done,
          state != rss_pkg::H_IDLE};
        default: prdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accAddr <= '0;
      accWdata <= '0;
    end else if (psel && penable && pwrite) begin
      if (paddr == rss_pkg::HREG_ADDR) accAddr <= pwdata[8:0];
      if (paddr == rss_pkg::HREG_WDATA) accWdata <= pwdata;
    end
  end

  // ****************************************
  // Wait counter
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitCnt <= '0;
    end else if (state == rss_pkg::H_PIN || state == rss_pkg::H_POLL) begin
      waitCnt <= waitCnt + TW'(1);
    end else begin
      waitCnt <= '0;
    end
  end

  assign timeUp = (state == rss_pkg::H_POLL) && waitCnt >= TW'(POLL_LIMIT_CYCLES - 1);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= rss_pkg::H_IDLE;
      link.hwResetPinOut <= 1'b1;
      link.hwResetPinOe <= 1'b0;
      link.busReq <= 1'b0;
      link.busWrite <= 1'b0;
      link.busAddr <= '0;
      link.busWdata <= '0;
      accRdata <= '0;
      done <= 1'b0;
      timeoutErr <= 1'b0;
      refused <= 1'b0;
      devReady <= 1'b0;
      thenSoft <= 1'b0;
    end else begin
      case (state)
        rss_pkg::H_IDLE: begin
          if (ctrlWr) begin
            done <= 1'b0;
            timeoutErr <= 1'b0;
            refused <= 1'b0;
            if (pwdata[rss_pkg::CTRL_PIN_BIT]) begin
              // drive pin low for hold time
              link.hwResetPinOut <= 1'b0;
              link.hwResetPinOe <= 1'b1;
              devReady <= 1'b0;
              state <= rss_pkg::H_PIN;
            end else if (pwdata[rss_pkg::CTRL_SOFT_BIT]) begin
              thenSoft <= 1'b1;
              state <= rss_pkg::H_POLL;
            end else if (pwdata[rss_pkg::CTRL_ACC_BIT]) begin
              // only wake write while not ready
              if (!devReady && !(accWr && accAddr[7:0] == rss_pkg::REG_BYTE_TEST)) begin
                refused <= 1'b1;
              end else begin
                link.busReq <= 1'b1;
                link.busWrite <= accWr;
                link.busAddr <= accAddr[7:0];
                link.busWdata <= accWdata;
                state <= rss_pkg::H_ACC;
              end
            end
          end
        end
        rss_pkg::H_PIN: begin
          if (waitCnt >= TW'(PIN_LOW_CYCLES - 1)) begin
            link.hwResetPinOut <= 1'b1;
            link.hwResetPinOe <= 1'b0;
            thenSoft <= 1'b0;
            state <= rss_pkg::H_POLL;
          end
        end
        rss_pkg::H_POLL: begin
          if (link.busAck) begin
            link.busReq <= 1'b0;
            if (link.busRdata[rss_pkg::PMT_READY_BIT]) begin
              devReady <= 1'b1;
              // soft reset only once ready seen
              if (thenSoft) begin
                state <= rss_pkg::H_HOST_SOFT_RESET_BIT;
              end else begin
                done <= 1'b1;
                state <= rss_pkg::H_IDLE;
              end
            end
          end else if (!link.busReq && timeUp) begin
            timeoutErr <= 1'b1;
            state <= rss_pkg::H_IDLE;
          end else if (!link.busReq) begin
            link.busReq <= 1'b1;
            link.busWrite <= 1'b0;
            link.busAddr <= rss_pkg::REG_POWER_MGMT_CTRL_REG;
          end
        end
        rss_pkg::H_HOST_SOFT_RESET_BIT: begin
          if (link.busAck) begin
            link.busReq <= 1'b0;
            devReady <= 1'b0;
            thenSoft <= 1'b0;
            state <= rss_pkg::H_POLL;
          end else if (!link.busReq) begin
            // Request two cycles after the poll ack, never back to back
            link.busReq <= 1'b1;
            link.busWrite <= 1'b1;
            link.busAddr <= rss_pkg::REG_HARDWARE_CONFIG_REG;
            link.busWdata <= 32'h0000_0001 << rss_pkg::HWCFG_SOFT_RST_BIT;
          end
        end
        rss_pkg::H_ACC: begin
          if (link.busAck) begin
            link.busReq <= 1'b0;
            if (!link.busWrite) accRdata <= link.busRdata;
            if (link.busWrite && link.busAddr == rss_pkg::REG_BYTE_TEST) devReady <= 1'b0;
            done <= 1'b1;
            state <= rss_pkg::H_IDLE;
          end
        end
        default: state <= rss_pkg::H_IDLE;
      endcase
    end
  end
endmodule

// *** verif/rss_checker.sv ***
// Assertions on the link between the host end and the device end
`timescale 1ns/100ps
module rss_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hwResetPinOe,
  input wire logic hwResetPinLevel,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic [31:0] busRdata,
  input wire logic busAck
);
  logic rdPmt, rdySeen, rdyRd;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Status read that returned the ready flag set
  assign rdyRd = busAck && rdPmt && busRdata[0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {rdPmt, rdySeen} <= 2'h0;
    end else begin
      rdPmt <= busReq && !busAck ? !busWrite && busAddr == 8'h08 : rdPmt;
      rdySeen <= hwResetPinLevel && (rdySeen || rdyRd);
    end
  end
  ack_once_a: assert property (busReq && !busAck |=> busAck ##1 !busAck)
    else $error("bad ack");
  req_drop_a: assert property (busAck |=> !busReq)
    else $error("req kept");
  req_hold_a: assert property (busReq && !busAck |=> busReq && $stable(busAddr)
    && $stable(busWdata) && $stable(busWrite)) else $error("req moved");
  pin_pullup_a: assert property (!hwResetPinOe |-> hwResetPinLevel)
    else $error("pin not pulled");
  pin_low_a: assert property ($fell(hwResetPinLevel) |-> !hwResetPinLevel [*8])
    else $error("pin pulse short");
  ready_low_a: assert property (rdyRd |-> $past(hwResetPinLevel, 8))
    else $error("ready in reset");
  ready_soon_a: assert property ($rose(hwResetPinLevel) |-> ##[1:400] rdyRd)
    else $error("ready late");
  soft_gate_a: assert property (busReq && busWrite && busAddr == 8'h04
    && busWdata[0] |-> rdySeen) else $error("soft too early");
  cover property (rdyRd);
  cover property ($rose(hwResetPinLevel));
  cover property (busReq && busWrite && busAddr == 8'h04 && busWdata[0]);
endmodule

// *** verif/testbench.sv ***
// Self-checking bench: APB stimulus on the host end, device end beside it
`timescale 1ns/100ps
module testbench;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, phyLinkUp, txValid;
  logic eepromReload, deviceReady, txGo, rnd;
  logic [7:0] paddr, straps, st;
  logic [31:0] pwdata, prdata, rd, hv, lf;
  logic [5:0] domainReset;
  logic [6:0] seen;
  int nMismatch, checked;
  rss_link_if link();
  rss_device #(.HW_READY_CYCLES(200), .PHY_RST_CYCLES(50), .WAKE_CYCLES(100)) rss_device_i (
    .clk, .resetn, .link, .straps, .phyLinkUp, .txValid, .domainReset, .eepromReload,
    .deviceReady, .txGo);
  rss_host #(.PIN_LOW_CYCLES(20), .POLL_LIMIT_CYCLES(2000)) rss_host_i (.clk, .resetn,
    .link, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  rss_checker rss_checker_i (.clk(clk), .resetn(resetn), .hwResetPinOe(link.hwResetPinOe),
    .hwResetPinLevel(link.hwResetPinLevel), .busReq(link.busReq), .busWrite(link.busWrite),
    .busAddr(link.busAddr), .busWdata(link.busWdata), .busRdata(link.busRdata),
    .busAck(link.busAck));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test;
    if (nMismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic idle;
    do apb(1'b0, 8'h10, 32'h0); while (rd[0] !== 1'b0);
  endtask
  // One device access through the host registers
  task automatic acc(logic wr, logic [7:0] a, logic [31:0] d);
    apb(1'b1, 8'h04, {23'h0, wr, a});
    apb(1'b1, 8'h08, d);
    apb(1'b1, 8'h00, 32'h4);
    idle();
    apb(1'b0, 8'h0c, 32'h0);
  endtask
  always @(posedge clk) begin
    lf <= lfsr(lf);
    if (rnd) {phyLinkUp, txValid} <= lf[1:0];
  end
  always @(negedge clk) seen <= seen | {eepromReload, domainReset};
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, straps, phyLinkUp, txValid} = '0;
    rnd = 1'b1;
    lf = 32'h9460a5a1;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    straps <= lf[7:0];
    @(posedge clk);
    apb(1'b1, 8'h00, 32'h1);
    repeat (10) @(posedge clk);
    chk("pin domains", {deviceReady, domainReset}, 7'h3f);
    idle();
    chk("pin status", rd[4:1], 4'h9);
    chk("domains free", {deviceReady, domainReset}, 7'h40);
    st = straps;
    acc(1'b0, 8'h18, 32'h0);
    chk("straps", rd, {24'h0, st});
    hv = {8'h0, lf[15:0], 8'h0};
    acc(1'b1, 8'h04, hv);
    straps <= ~st;
    seen = 7'h0;
    apb(1'b1, 8'h00, 32'h2);
    idle();
    chk("soft status", rd[4:1], 4'h9);
    chk("soft domains", seen, 7'h5a);
    acc(1'b0, 8'h04, 32'h0);
    chk("soft cfg", rd & 32'hffff01, hv & 32'h00ff00);
    acc(1'b0, 8'h18, 32'h0);
    chk("soft straps", rd, {24'h0, st});
    acc(1'b0, 8'h0c, 32'h0);
    chk("eeprom busy", rd[31], 1'b1);
    acc(1'b0, 8'h1c, 32'h0);
    chk("unmapped", rd, 32'h0);
    rnd = 1'b0;
    {phyLinkUp, txValid} <= 2'h3;
    for (int i = 0; i < 2; i++) begin
      hv = i ? 32'h8000 : 32'h400;
      acc(1'b1, i ? 8'h10 : 8'h08, hv);
      chk("phy domains", {txGo, domainReset}, 7'h20);
      repeat (60) @(posedge clk);
      acc(1'b0, i ? 8'h10 : 8'h08, 32'h0);
      chk("phy clear", {txGo, rd[15:0] & hv[15:0]}, {1'b1, 16'h0});
    end
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    finish_test();
  end
endmodule
